// File: core/tbnp_core.sv
// Token bus network parameters, polling, token and host window logic
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
module tbnp_core #(
  parameter int CLKS_PER_MS = tbnp_pkg::CYC_PER_MS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic [62:0] node_alive,
  input  wire logic [31:0] peer_param,
  input  wire logic        token_in,
  input  wire logic        have_data,
  input  wire logic        tx_done,
  input  wire logic        cycle_done_in,
  input  wire logic        event_req,
  output logic             token_out,
  output logic      [5:0]  token_dest,
  output logic             poll_strobe,
  output logic      [5:0]  poll_addr,
  output logic             event_grant,
  output logic             event_deny,
  output logic             cycle_start,
  output logic             link_active
);
  //////////////////////////////////////////////////////////////////////////
  // Lowest live node not above the limit, zero if none
  function automatic logic [5:0] lowest(input logic [62:0] m,
                                        input logic [5:0]  lim);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 62; i >= 1; i--) begin
      if (m[i] && 6'(i) <= lim) r = 6'(i);
    end
    return r;
  endfunction

  // Next live node above me, wrapping to the lowest
  function automatic logic [5:0] next_up(input logic [62:0] m,
                                         input logic [5:0]  me,
                                         input logic [5:0]  lim);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 62; i >= 1; i--) begin
      if (m[i] && 6'(i) > me && 6'(i) <= lim) r = 6'(i);
    end
    if (r == 6'h00) r = lowest(m, lim);
    return r;
  endfunction

  // Every field of a parameter word inside its range
  function automatic logic param_ok(input logic [31:0] w);
    logic [7:0] c;
    logic [7:0] n;
    logic [7:0] p;
    logic [7:0] f;
    c = w[tbnp_pkg::F_CYC+:8];
    n = w[tbnp_pkg::F_MAXN+:8];
    p = w[tbnp_pkg::F_POLL+:8];
    f = w[tbnp_pkg::F_FRM+:8];
    return (c == 8'h00 || c >= tbnp_pkg::CYC_MIN) &&
           n >= tbnp_pkg::MAXN_MIN && n <= tbnp_pkg::MAXN_MAX &&
           p >= tbnp_pkg::POLL_MIN && p <= tbnp_pkg::POLL_MAX &&
           f >= tbnp_pkg::FRM_MIN;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // State
  logic [1:0]  ctrl_reg, ctrl_next;
  logic [6:0]  net_reg, net_next;
  logic [3:0]  unit_reg, unit_next;
  logic [31:0] param_reg, param_next;
  logic [5:0]  node_reg, node_next;
  logic [31:0] win_reg, win_next;
  logic [3:0]  istat_reg, istat_next;
  logic [3:0]  imask_reg, imask_next;
  logic        perr_reg, perr_next;
  logic        uerr_reg, uerr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;
  logic        irq_reg, irq_next;
  logic [5:0]  poller_reg, poller_next;
  logic [3:0]  evt;
  logic        setup, acc, wr;
  logic [31:0] act;
  logic        am_poller;

  assign setup     = psel && !penable;
  assign acc       = psel && penable && pready_reg;
  assign wr        = acc && pwrite;
  assign am_poller = (poller_reg == node_reg);
  // Non-pollers follow the parameters broadcast by the polling unit
  assign act = am_poller ? param_reg : peer_param;

  //////////////////////////////////////////////////////////////////////////
  // APB slave, registers and interrupt status
  always_comb begin
    ctrl_next    = ctrl_reg;
    net_next     = net_reg;
    unit_next    = unit_reg;
    param_next   = param_reg;
    node_next    = node_reg;
    imask_next   = imask_reg;
    perr_next    = perr_reg;
    uerr_next    = uerr_reg;
    evt          = 4'h0;
    prdata_next  = prdata_reg;
    pready_next  = setup;
    pslverr_next = 1'b0;
    if (wr && paddr == tbnp_pkg::A_CTRL) begin
      ctrl_next = pwdata[1:0];
    end else if (wr && paddr == tbnp_pkg::A_NET) begin
      if (pwdata <= tbnp_pkg::NET_MAX) net_next = pwdata[6:0];
    end else if (wr && paddr == tbnp_pkg::A_UNIT) begin
      uerr_next = (pwdata > tbnp_pkg::UNIT_MAX);
      if (pwdata <= tbnp_pkg::UNIT_MAX) unit_next = pwdata[3:0];
      else evt[tbnp_pkg::I_UNIT] = 1'b1;
    end else if (wr && paddr == tbnp_pkg::A_PARAM) begin
      // Refused while the link runs, since peers rely on a steady set
      perr_next = !param_ok(pwdata) || ctrl_reg[0];
      if (param_ok(pwdata) && !ctrl_reg[0]) param_next = pwdata;
      else evt[tbnp_pkg::I_PARAM] = 1'b1;
    end else if (wr && paddr == tbnp_pkg::A_NODE) begin
      if (pwdata >= tbnp_pkg::NODE_MIN && pwdata <= tbnp_pkg::NODE_MAX)
        node_next = pwdata[5:0];
    end else if (wr && paddr == tbnp_pkg::A_IMASK) begin
      imask_next = pwdata[3:0];
    end
    // Read data is captured in setup so it stands through access
    if (setup) begin
      if (paddr == tbnp_pkg::A_CTRL) begin
        prdata_next = {30'h0, ctrl_reg};
      end else if (paddr == tbnp_pkg::A_STATUS) begin
        prdata_next = {10'h0, poller_reg, ctrl_reg[0], 6'h0, am_poller,
                       4'h0, uerr_reg, 2'h0, perr_reg};
      end else if (paddr == tbnp_pkg::A_NET) begin
        prdata_next = {25'h0, net_reg};
      end else if (paddr == tbnp_pkg::A_UNIT) begin
        prdata_next = {28'h0, unit_reg};
      end else if (paddr == tbnp_pkg::A_PARAM) begin
        prdata_next = param_reg;
      end else if (paddr == tbnp_pkg::A_NODE) begin
        prdata_next = {26'h0, node_reg};
      end else if (paddr == tbnp_pkg::A_WIN) begin
        prdata_next = win_reg;
      end else if (paddr == tbnp_pkg::A_ISTAT) begin
        prdata_next = {28'h0, istat_reg};
      end else if (paddr == tbnp_pkg::A_IMASK) begin
        prdata_next = {28'h0, imask_reg};
      end else begin
        prdata_next  = 32'h0;
        pslverr_next = 1'b1;
      end
    end
    // Window bases follow the unit number one cycle later
    win_next = {tbnp_pkg::DATA_MEM_BASE +
                tbnp_pkg::DATA_MEM_STEP * {12'h0, unit_reg},
                tbnp_pkg::CORE_IO_BASE +
                tbnp_pkg::CORE_IO_STEP * {12'h0, unit_reg}};
    // above; lowest live node, counting ourselves
    poller_next = lowest(node_alive | (63'h1 << node_reg), 6'h3E);
    evt[tbnp_pkg::I_DENY] = event_deny;
    evt[tbnp_pkg::I_CYC]  = cycle_start;
    // Set wins over a write-one clear in the same cycle
    istat_next = istat_reg;
    if (wr && paddr == tbnp_pkg::A_ISTAT) istat_next = istat_reg & ~pwdata[3:0];
    istat_next = istat_next | evt;
    irq_next   = |(istat_next & imask_next);
  end

  // Register bank
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg    <= 2'h0;
      net_reg     <= 7'h00;
      unit_reg    <= tbnp_pkg::RST_UNIT;
      param_reg   <= tbnp_pkg::RST_PARAM;
      node_reg    <= tbnp_pkg::RST_NODE;
      win_reg     <= {tbnp_pkg::DATA_MEM_BASE, tbnp_pkg::CORE_IO_BASE};
      istat_reg   <= 4'h0;
      imask_reg   <= 4'h0;
      perr_reg    <= 1'b0;
      uerr_reg    <= 1'b0;
      prdata_reg  <= 32'h0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      irq_reg     <= 1'b0;
      poller_reg  <= tbnp_pkg::RST_NODE;
    end else begin
      ctrl_reg    <= ctrl_next;
      net_reg     <= net_next;
      unit_reg    <= unit_next;
      param_reg   <= param_next;
      node_reg    <= node_next;
      win_reg     <= win_next;
      istat_reg   <= istat_next;
      imask_reg   <= imask_next;
      perr_reg    <= perr_next;
      uerr_reg    <= uerr_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      irq_reg     <= irq_next;
      poller_reg  <= poller_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Cycle timer, polling, token and event budget
  tbnp_pkg::tbnp_tok_e tok_reg, tok_next;
  logic [23:0] tick_reg, tick_next;
  logic [7:0]  ms_reg, ms_next;
  logic [5:0]  left_reg, left_next;
  logic [5:0]  ptr_reg, ptr_next;
  logic [8:0]  ecnt_reg, ecnt_next;
  logic        tout_reg, tout_next;
  logic [5:0]  tdest_reg, tdest_next;
  logic        pstb_reg, pstb_next;
  logic [5:0]  paddr_reg, paddr_next;
  logic        egr_reg, egr_next;
  logic        edn_reg, edn_next;
  logic        cst_reg, cst_next;
  logic        timed, expire;
  logic [5:0]  maxn, cur;
  logic [8:0]  allowed;

  assign maxn  = act[tbnp_pkg::F_MAXN+:6];
  assign timed = ctrl_reg[0] && act[tbnp_pkg::F_CYC+:8] != 8'h00;
  assign expire = timed && tick_reg == 24'(CLKS_PER_MS - 1) &&
                  ms_reg == act[tbnp_pkg::F_CYC+:8] - 8'h01;
  // 10 frames give 4 events, each 3 more frames one more event
  assign allowed = ({1'b0, act[tbnp_pkg::F_FRM+:8]} +
                    tbnp_pkg::EVT_STEP_FRM * tbnp_pkg::EVT_BASE_CNT -
                    tbnp_pkg::EVT_BASE_FRM) / tbnp_pkg::EVT_STEP_FRM;
  assign cur = (ptr_reg == 6'h00 || ptr_reg > maxn) ? 6'h01 : ptr_reg;

  always_comb begin
    tok_next   = tok_reg;
    tout_next  = 1'b0;
    tdest_next = tdest_reg;
    pstb_next  = 1'b0;
    paddr_next = paddr_reg;
    left_next  = left_reg;
    ptr_next   = ptr_reg;
    egr_next   = 1'b0;
    edn_next   = 1'b0;
    ecnt_next  = ecnt_reg;
    // Timed cycles ignore events; untimed ones end with the network
    tick_next = 24'h0;
    ms_next   = 8'h00;
    if (timed) begin
      tick_next = tick_reg + 24'h1;
      ms_next   = ms_reg;
      if (tick_reg == 24'(CLKS_PER_MS - 1)) begin
        tick_next = 24'h0;
        ms_next   = expire ? 8'h00 : ms_reg + 8'h01;
      end
    end
    cst_next = timed ? expire : cycle_done_in;
    // Token passes on at once when there is nothing to send
    case (tok_reg)
      tbnp_pkg::TOK_IDLE: begin
        if (token_in && have_data) begin
          tok_next = tbnp_pkg::TOK_HOLD;
        end else if (token_in) begin
          tout_next  = 1'b1;
          tdest_next = next_up(node_alive, node_reg, maxn);
        end
      end
      tbnp_pkg::TOK_HOLD: begin
        if (tx_done) begin
          tok_next   = tbnp_pkg::TOK_IDLE;
          tout_next  = 1'b1;
          tdest_next = next_up(node_alive, node_reg, maxn);
        end
      end
      default: tok_next = tbnp_pkg::TOK_IDLE;
    endcase
    // Poll a fixed count per cycle, wrapping to address 1 after the maximum address
    if (cst_reg && am_poller) begin
      left_next = act[tbnp_pkg::F_POLL+:6];
    end else if (left_reg != 6'h00) begin
      pstb_next  = 1'b1;
      paddr_next = cur;
      ptr_next   = (cur >= maxn) ? 6'h01 : cur + 6'h01;
      left_next  = left_reg - 6'h01;
    end
    // Budget applies only while data links run
    if (cst_reg) ecnt_next = 9'h000;
    if (event_req) begin
      if (!ctrl_reg[0]) begin
        egr_next = 1'b1;
      end else if (ecnt_reg < allowed) begin
        egr_next  = 1'b1;
        ecnt_next = ecnt_next + 9'h001;
      end else begin
        edn_next = 1'b1;
      end
    end
  end

  // Network side registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tok_reg   <= tbnp_pkg::TOK_IDLE;
      tick_reg  <= 24'h0;
      ms_reg    <= 8'h00;
      left_reg  <= 6'h00;
      ptr_reg   <= 6'h01;
      ecnt_reg  <= 9'h000;
      tout_reg  <= 1'b0;
      tdest_reg <= 6'h00;
      pstb_reg  <= 1'b0;
      paddr_reg <= 6'h00;
      egr_reg   <= 1'b0;
      edn_reg   <= 1'b0;
      cst_reg   <= 1'b0;
    end else begin
      tok_reg   <= tok_next;
      tick_reg  <= tick_next;
      ms_reg    <= ms_next;
      left_reg  <= left_next;
      ptr_reg   <= ptr_next;
      ecnt_reg  <= ecnt_next;
      tout_reg  <= tout_next;
      tdest_reg <= tdest_next;
      pstb_reg  <= pstb_next;
      paddr_reg <= paddr_next;
      egr_reg   <= egr_next;
      edn_reg   <= edn_next;
      cst_reg   <= cst_next;
    end
  end

  // Outputs straight from flops
  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign irq         = irq_reg;
  assign token_out   = tout_reg;
  assign token_dest  = tdest_reg;
  assign poll_strobe = pstb_reg;
  assign poll_addr   = paddr_reg;
  assign event_grant = egr_reg;
  assign event_deny  = edn_reg;
  assign cycle_start = cst_reg;
  assign link_active = ctrl_reg[0];

  //////////////////////////////////////////////////////////////////////////
  // Checks; helper counts cycles between timed starts
  logic [31:0] gap_reg;
  logic        steady_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_reg    <= 32'h0;
      steady_reg <= 1'b0;
    end else begin
      gap_reg    <= cst_reg ? 32'h0 : gap_reg + 32'h1;
      steady_reg <= cst_reg ? timed : (steady_reg && timed &&
                                       $stable(act[7:0]));
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_NET_RANGE: assert property (
    wr && paddr == tbnp_pkg::A_NET && pwdata > tbnp_pkg::NET_MAX
    |=> $stable(net_reg)) else $error("bad network address stored");
  AST_PEER_PARAM: assert property (
    !am_poller |-> act == peer_param) else $error("own params used");
  AST_CYC_FIXED: assert property (
    cst_reg && steady_reg && timed |->
    gap_reg == 32'(CLKS_PER_MS) * {24'h0, act[7:0]} - 32'h1)
    else $error("timed cycle length wrong");
  AST_UNTIMED: assert property (
    !ctrl_reg[0] && !cycle_done_in |=> !cst_reg)
    else $error("cycle start without link");
  AST_POLL_MAX: assert property (
    pstb_next |-> paddr_next <= maxn && paddr_next != 6'h00)
    else $error("polled above maximum");
  AST_POLL_CNT: assert property (
    cst_reg && am_poller |=> left_reg == $past(act[21:16]))
    else $error("poll count wrong");
  AST_EVT_LIMIT: assert property (
    event_req && ctrl_reg[0] && ecnt_reg >= allowed && !cst_reg
    |=> edn_reg && !egr_reg) else $error("event over budget granted");
  AST_UNIT_ERR: assert property (
    wr && paddr == tbnp_pkg::A_UNIT && pwdata > tbnp_pkg::UNIT_MAX
    |=> uerr_reg && $stable(unit_reg)) else $error("unit error missed");
  AST_PARAM_KEEP: assert property (
    wr && paddr == tbnp_pkg::A_PARAM && !param_ok(pwdata)
    |=> $stable(param_reg) ##1 istat_reg[0]) else $error("bad param kept");
  AST_TOKEN_FWD: assert property (
    token_in && !have_data && tok_reg == tbnp_pkg::TOK_IDLE
    |=> tout_reg) else $error("idle token not passed");
  AST_WIN: assert property (
    ##1 win_reg[15:0] == tbnp_pkg::CORE_IO_BASE +
    tbnp_pkg::CORE_IO_STEP * {12'h0, $past(unit_reg)})
    else $error("status window base wrong");

  COV_TIMED: cover property (cst_reg && steady_reg);
  COV_DENY: cover property (edn_reg);
  COV_POLL: cover property (pstb_reg [*3]);
  COV_TOKEN: cover property (tok_reg == tbnp_pkg::TOK_HOLD ##1 tout_reg);
endmodule

// File: core/tbnp_pkg.sv
// Shared constants and types for the token bus network parameter block
package tbnp_pkg;
  // Register byte offsets
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_NET    = 8'h08;
  localparam logic [7:0] A_UNIT   = 8'h0C;
  localparam logic [7:0] A_PARAM  = 8'h10;
  localparam logic [7:0] A_NODE   = 8'h14;
  localparam logic [7:0] A_WIN    = 8'h18;
  localparam logic [7:0] A_ISTAT  = 8'h1C;
  localparam logic [7:0] A_IMASK  = 8'h20;
  // Parameter word field positions
  localparam int F_CYC  = 0;
  localparam int F_MAXN = 8;
  localparam int F_POLL = 16;
  localparam int F_FRM  = 24;
  // Values after reset: cycle time 0 means automatic
  localparam logic [7:0]  RST_CYC   = 8'h00;
  localparam logic [7:0]  RST_MAXN  = 8'h3E;
  localparam logic [7:0]  RST_POLL  = 8'h04;
  localparam logic [7:0]  RST_FRM   = 8'h0A;
  localparam logic [31:0] RST_PARAM = {RST_FRM, RST_POLL, RST_MAXN, RST_CYC};
  localparam logic [5:0]  RST_NODE  = 6'h01;
  localparam logic [3:0]  RST_UNIT  = 4'h0;
  // Setting ranges
  localparam logic [7:0]  CYC_MIN  = 8'h05;
  localparam logic [7:0]  MAXN_MIN = 8'h02;
  localparam logic [7:0]  MAXN_MAX = 8'h3E;
  localparam logic [7:0]  POLL_MIN = 8'h01;
  localparam logic [7:0]  POLL_MAX = 8'h3E;
  localparam logic [7:0]  FRM_MIN  = 8'h05;
  localparam logic [31:0] NET_MAX  = 32'h0000007F;
  localparam logic [31:0] UNIT_MAX = 32'h0000000F;
  localparam logic [31:0] NODE_MIN = 32'h00000001;
  localparam logic [31:0] NODE_MAX = 32'h0000003E;
  // Host word windows
  localparam logic [15:0] CORE_IO_BASE  = 16'h05DC;
  localparam logic [15:0] CORE_IO_STEP  = 16'h0019;
  localparam logic [15:0] DATA_MEM_BASE = 16'h07D0;
  localparam logic [15:0] DATA_MEM_STEP = 16'h0064;
  // Event budget: base frames, base events, frames per extra event
  localparam logic [8:0] EVT_BASE_FRM = 9'h00A;
  localparam logic [8:0] EVT_BASE_CNT = 9'h004;
  localparam logic [8:0] EVT_STEP_FRM = 9'h003;
  // Interrupt status bits
  localparam int I_PARAM = 0;
  localparam int I_UNIT  = 1;
  localparam int I_DENY  = 2;
  localparam int I_CYC   = 3;
  // Cycle time unit is one millisecond
  localparam int MS_NS      = 1000000;
  localparam int CLK_NS     = 100;
  localparam int CYC_PER_MS = (MS_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [0:0] {
    TOK_IDLE = 1'b0,
    TOK_HOLD = 1'b1
  } tbnp_tok_e;
endpackage

// File: bench/tbnp_peer.sv
// Peer-node model driving the network side of the block
`timescale 1ns/1ns
module tbnp_peer #(
  parameter logic [31:0] PEER_WORD = 32'h0A043E00
) (
  input  wire logic        pclk,
  output logic      [62:0] node_alive,
  output logic      [31:0] peer_param,
  output logic             token_in,
  output logic             have_data,
  output logic             tx_done,
  output logic             cycle_done_in,
  output logic             event_req
);
  logic [3:0] pls = 4'h0;
  // Every peer event is a single-cycle pulse
  assign {event_req, cycle_done_in, tx_done, token_in} = pls;
  assign peer_param = PEER_WORD;
  initial begin
    node_alive = 63'h0;
    have_data  = 1'b0;
  end
  // Data flag rides with the token, as a passing peer frames it
  task strobe(input logic [3:0] p, input logic d);
    @(posedge pclk);
    pls       <= p;
    have_data <= d;
    @(posedge pclk);
    pls <= 4'h0;
  endtask
  // Membership changes land on a clock edge
  task set_alive(input logic [62:0] v);
    @(posedge pclk);
    node_alive <= v;
  endtask
endmodule

// File: bench/token_bus_network_params_bench.sv
// Self-checking bench for the token bus network parameter block
`timescale 1ns/1ns
module token_bus_network_params_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_val, exp_param, peer_param;
  logic        token_out, poll_strobe, event_grant, event_deny;
  logic        cycle_start, link_active, err_seen, link;
  logic        token_in, have_data, tx_done, cycle_done_in, event_req;
  logic [62:0] node_alive;
  logic [5:0]  token_dest, poll_addr, max_poll;
  int          errors, total_checks, cyc, seed, n_grant, n_deny;
  int          n_poll, n_tok, u, v, exp_net;
  int          cs_t[$];
  tbnp_core #(.CLKS_PER_MS(10)) dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
    .node_alive, .peer_param, .token_in, .have_data, .tx_done,
    .cycle_done_in, .event_req, .token_out, .token_dest, .poll_strobe,
    .poll_addr, .event_grant, .event_deny, .cycle_start, .link_active);
  tbnp_peer peer (.pclk, .node_alive, .peer_param, .token_in, .have_data,
    .tx_done, .cycle_done_in, .event_req);
  //////////////////////////////////////////////////////////////////////////
  // Clock at 10 MHz
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Tally network answers; the ceiling cuts a hang short
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      final_report();
    end
    if (event_grant === 1'b1) n_grant++;
    if (event_deny === 1'b1) n_deny++;
    if (token_out === 1'b1) n_tok++;
    if (cycle_start === 1'b1) cs_t.push_back(cyc);
    if (poll_strobe === 1'b1) begin
      n_poll++;
      if (poll_addr > max_poll) max_poll = poll_addr;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task final_report();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    rd_val   = prdata;
    err_seen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd_val);
  endtask
  // Model: a word is kept only if every field is legal and link is off
  task put_param(input logic [31:0] p);
    logic ok;
    ok = (p[7:0] == 8'h0 || p[7:0] >= 8'h5) && p[15:8] >= 8'h2 &&
         p[15:8] <= 8'h3E && p[23:16] >= 8'h1 && p[23:16] <= 8'h3E &&
         p[31:24] >= 8'h5 && !link;
    if (ok) exp_param = p;
    apb(1'b1, tbnp_pkg::A_PARAM, p);
    rd(tbnp_pkg::A_PARAM, exp_param, "param");
    apb(1'b0, tbnp_pkg::A_STATUS, 32'h0);
    chk("param error", {31'h0, !ok}, {31'h0, rd_val[0]});
  endtask
  task set_link(input logic on);
    link = on;
    apb(1'b1, tbnp_pkg::A_CTRL, {31'h0, on});
    // Flag flop settles one edge after the access edge
    @(posedge pclk);
    chk("link active", {31'h0, on}, {31'h0, link_active});
  endtask
  task ev_burst(input int k);
    n_grant = 0;
    n_deny  = 0;
    repeat (k) peer.strobe(4'h8, 1'b0);
    repeat (3) @(posedge pclk);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    seed = 90;
    link = 1'b0;
    exp_net = 0;
    exp_param = 32'h0A043E00;
    max_poll = 6'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and network address range, random settings
    rd(tbnp_pkg::A_PARAM, 32'h0A043E00, "param reset");
    repeat (6) begin
      v = $random(seed) & 255;
      apb(1'b1, tbnp_pkg::A_NET, 32'(v));
      if (v <= 127) exp_net = v;
      rd(tbnp_pkg::A_NET, 32'(exp_net), "net");
    end
    // Host windows for every unit number, then one out of range
    for (u = 0; u < 17; u++) begin
      apb(1'b1, tbnp_pkg::A_UNIT, 32'(u));
      if (u < 16) rd(tbnp_pkg::A_WIN, 32'(((2000 + 100 * u) << 16) |
                     (1500 + 25 * u)), "window");
    end
    rd(tbnp_pkg::A_UNIT, 32'hF, "unit kept");
    apb(1'b0, tbnp_pkg::A_STATUS, 32'h0);
    chk("unit error", 32'h1, {31'h0, rd_val[3]});
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err_seen});
    // Sticky unit reject raises irq once unmasked; a write-one clear drops it
    apb(1'b1, tbnp_pkg::A_IMASK, 32'h2);
    repeat (3) @(posedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, tbnp_pkg::A_ISTAT, 32'h2);
    repeat (3) @(posedge pclk);
    chk("irq clear", 32'h0, {31'h0, irq});
    // Bad cycle time refused, then a legal set kept
    put_param(32'h0D030504);
    put_param(32'h0D030500);
    set_link(1'b1);
    put_param(32'h0D030508);
    apb(1'b1, tbnp_pkg::A_IMASK, 32'h1);
    repeat (3) @(posedge pclk);
    chk("irq param", 32'h1, {31'h0, irq});
    // Three polling cycles, each polling the set count, none above the max
    n_poll = 0;
    repeat (3) begin
      peer.strobe(4'h4, 1'b0);
      repeat (8) @(posedge pclk);
    end
    chk("polls", 32'd9, 32'(n_poll));
    chk("poll max", 32'h1, {31'h0, max_poll <= 6'd5});
    // Budget of 13 frames: 4 events for 10, one more per 3 frames
    ev_burst(7);
    chk("grants", 32'(4 + (13 - 10) / 3), 32'(n_grant));
    chk("denies", 32'd2, 32'(n_deny));
    peer.strobe(4'h4, 1'b0);
    ev_burst(1);
    chk("grant new cycle", 32'h1, 32'(n_grant));
    // Timed cycles of 5 ms stay fixed despite events and cycle ends
    set_link(1'b0);
    put_param(32'h0D030505);
    set_link(1'b1);
    cs_t.delete();
    ev_burst(4);
    peer.strobe(4'h4, 1'b0);
    repeat (160) @(posedge pclk);
    chk("cycle count", 32'h1, {31'h0, cs_t.size() >= 3});
    for (v = 1; v < cs_t.size(); v++)
      chk("cycle len", 32'd50, 32'(cs_t[v] - cs_t[v - 1]));
    // Link off: no timer, no budget
    set_link(1'b0);
    cs_t.delete();
    ev_burst(7);
    repeat (120) @(posedge pclk);
    chk("untimed", 32'h0, 32'(cs_t.size()));
    chk("free events", 32'd7, 32'(n_grant));
    // Token ring: live nodes 3 and 7; own max node 5, the poller's is 62
    peer.set_alive(63'h88);
    apb(1'b1, tbnp_pkg::A_NODE, 32'h4);
    repeat (3) @(posedge pclk);
    apb(1'b0, tbnp_pkg::A_STATUS, 32'h0);
    chk("poller", 32'h3, {26'h0, rd_val[21:16]});
    chk("not poller", 32'h0, {31'h0, rd_val[8]});
    n_tok = 0;
    peer.strobe(4'h1, 1'b0);
    repeat (3) @(posedge pclk);
    // Not the poller: the peer's limit of 62 lets node 7 take the token
    chk("peer dest", 32'h7, {26'h0, token_dest});
    apb(1'b1, tbnp_pkg::A_NODE, 32'h1);
    peer.strobe(4'h1, 1'b0);
    repeat (3) @(posedge pclk);
    chk("next dest", 32'h3, {26'h0, token_dest});
    peer.strobe(4'h1, 1'b1);
    repeat (3) @(posedge pclk);
    chk("held", 32'd2, 32'(n_tok));
    peer.strobe(4'h2, 1'b0);
    repeat (3) @(posedge pclk);
    chk("released", 32'd3, 32'(n_tok));
    final_report();
  end
endmodule
